// >>> design/tpw_defines.svh
// Constants for the two-phase interleaved drive timing core.
// Assumes a single 10 MHz device clock; included by its bare name.
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH
// Device clock period in ns
`define TPW_CLK_NS     100
// Default switching period in ns (100 kHz)
`define TPW_PERIOD_NS  10000
// Settling time before a current sample, in ns
`define TPW_SETTLE_NS  500
// Width of level and current words
`define TPW_DATA_W     8
// Shift of the balance error filter
`define TPW_FILT_SH    2
`endif

// >>> design/tpw_pkg.sv
// Types shared by the interleaved drive timing core.
// Assumes nothing of its surroundings.
package tpw_pkg;
  // Per-channel drive state, one-hot
  typedef enum logic [2:0] {
    TPW_FORCED_OFF = 3'h1,
    TPW_ARMED      = 3'h2,
    TPW_DRIVE_HIGH = 3'h4
  } tpw_state_t;
endpackage : tpw_pkg

// >>> design/tpw_timing.sv
// Timing core of a two-phase interleaved buck controller.
// Assumes level and current words from converters, already scaled to the
// switching-period count, and a digital disable level from the frequency pin.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defines.svh"

// Summary of operation
// R1: Cycle ends at each phase one falling edge
// R2: Cycle period equals programmed switching period
// R3: Phase two ends half cycle after one
// R4: Fallen output held low quarter cycle minimum
// R5: Rise allowed only after forced off expires
// R6: Compare corrected level against sawtooth ramp
// R7: Crossing the ramp drives the output high
// R8: High output stays until next termination
// R9: Sample current once in forced off
// R10: Held samples feed balance and mean output
// R11: Mean current is half the sample sum
// R12: Filtered balance error corrects each level
// R13: Driver swaps switches on each drive edge
// R14: Low disable pin stops all switching
// R15: Inputs synchronised; reset holds drives low
// R16: Half and quarter derive from period count
module tpw_timing
  import tpw_pkg::*;
#(
  parameter int PERIOD_CYC = `TPW_PERIOD_NS / `TPW_CLK_NS,
  parameter int DW         = `TPW_DATA_W
)(
  input  wire logic          clk_in,                // Device clock
  input  wire logic          rst_in,                // Synchronous reset
  input  wire logic          freq_set_disable_in,   // Low disables
  input  wire logic [DW-1:0] error_amp_output_in,   // Error amp level
  input  wire logic [DW-1:0] phase_one_current_in,  // Channel 1 sense
  input  wire logic [DW-1:0] phase_two_current_in,  // Channel 2 sense
  output var  logic          phase_one_drive_out,   // Channel 1 drive
  output var  logic          phase_two_drive_out,   // Channel 2 drive
  output var  logic [DW-1:0] mean_phase_current_out,// Mean sample
  output var  logic          switching_active_out   // Running
);
  import tpw_pkg::*;

  // Period split from one count; settle slots from the settle time
  localparam int CW     = $clog2(PERIOD_CYC);
  localparam int HALF   = PERIOD_CYC / 2;                 // [R16]
  localparam int QTR    = (PERIOD_CYC + 3) / 4;           // [R16]
  localparam int SETTLE = (`TPW_SETTLE_NS + `TPW_CLK_NS - 1) / `TPW_CLK_NS;
  localparam int AW     = DW + 2;                         // Signed width
  localparam logic [CW-1:0] LAST   = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] HALF_C = CW'(HALF);
  localparam logic [CW-1:0] QTR_C  = CW'(QTR);
  localparam logic [CW-1:0] SET_C  = CW'(SETTLE);

  // Two-flop synchronisers for every outside input
  logic          en_s1_r, en_s2_r;
  logic [DW-1:0] amp_s1_r, amp_s2_r;
  logic [DW-1:0] cur_s1_r [2];
  logic [DW-1:0] cur_s2_r [2];

  // Synchroniser flops, first stage read only by second
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      en_s1_r  <= 1'b0;
      en_s2_r  <= 1'b0;
      amp_s1_r <= '0;
      amp_s2_r <= '0;
      cur_s1_r <= '{default: '0};
      cur_s2_r <= '{default: '0};
    end
    else
    begin
      en_s1_r     <= freq_set_disable_in;                 // [R15]
      en_s2_r     <= en_s1_r;
      amp_s1_r    <= error_amp_output_in;
      amp_s2_r    <= amp_s1_r;
      cur_s1_r[0] <= phase_one_current_in;
      cur_s1_r[1] <= phase_two_current_in;
      cur_s2_r    <= cur_s1_r;
    end
  end

  // Cycle counter; slot LAST is the termination tick
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          act_r, act_nxt;

  // Next count: held at zero while disabled
  always_comb
  begin
    act_nxt = en_s2_r;
    if (!en_s2_r)
      cnt_nxt = '0;                                       // [R14]
    else if (cnt_r == LAST)
      cnt_nxt = '0;                                       // [R2]
    else
      cnt_nxt = cnt_r + 1'b1;
  end

  // Counter registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt_r <= '0;
      act_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  // Mean of the held samples, registered
  logic [DW-1:0] samp_r [2];
  logic [DW-1:0] mean_r, mean_nxt;
  logic [DW:0]   sum_w;

  // Sum then halve
  always_comb
  begin
    sum_w    = {1'b0, samp_r[0]} + {1'b0, samp_r[1]};
    mean_nxt = sum_w[DW:1];                               // [R11]
  end

  // Mean register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mean_r <= '0;
    else
      mean_r <= mean_nxt;
  end

  logic [CW-1:0] ph   [2];  // Channel-local slot
  tpw_state_t    st_r [2];  // Channel state
  logic          drv_r[2];  // Channel drive
  logic          cmp  [2];  // Ramp crossed

  // Per-channel drive, sampling and balance
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    tpw_state_t           st_nxt;
    logic                 drv_nxt;
    logic [DW-1:0]        samp_nxt;
    logic signed [AW-1:0] acc_r, acc_nxt, berr, lvl;
    logic [CW-1:0]        ramp;

    // Channel two runs half a period behind
    if (i == 0)
    begin : g_p1
      assign ph[i] = cnt_r;                               // [R1]
    end
    else
    begin : g_p2
      assign ph[i] = (cnt_r >= HALF_C) ? cnt_r - HALF_C
                   : cnt_r + CW'(PERIOD_CYC - HALF);      // [R3]
    end

    // Corrected level against a falling sawtooth
    always_comb
    begin
      ramp   = LAST - ph[i];
      berr   = AW'(signed'({2'b00, samp_r[i]}))
             - AW'(signed'({2'b00, mean_r}));             // [R12]
      lvl    = AW'(signed'({2'b00, amp_s2_r})) - acc_r;   // [R6]
      cmp[i] = (lvl > AW'(signed'({2'b00, ramp})));       // [R6]
    end

    // State, drive, sample and filter next values
    always_comb
    begin
      st_nxt   = st_r[i];
      drv_nxt  = drv_r[i];
      samp_nxt = samp_r[i];
      acc_nxt  = acc_r;
      if (!en_s2_r)
      begin
        st_nxt  = TPW_FORCED_OFF;                         // [R14]
        drv_nxt = 1'b0;
      end
      else if (ph[i] == LAST)
      begin
        st_nxt  = TPW_FORCED_OFF;                         // [R8]
        drv_nxt = 1'b0;                                   // [R1]
        acc_nxt = acc_r + ((berr - acc_r) >>> `TPW_FILT_SH); // [R12]
      end
      else
      begin
        case (st_r[i])
          TPW_FORCED_OFF:
          begin
            if (ph[i] == SET_C)
              samp_nxt = cur_s2_r[i];                     // [R9]
            if (ph[i] == QTR_C - 1'b1)
              st_nxt = TPW_ARMED;                         // [R4]
          end
          TPW_ARMED:
          begin
            if (cmp[i])
            begin
              st_nxt  = TPW_DRIVE_HIGH;                   // [R5]
              drv_nxt = 1'b1;                             // [R7]
            end
          end
          TPW_DRIVE_HIGH:
            drv_nxt = 1'b1;                               // [R8]
          default:
          begin
            st_nxt  = TPW_FORCED_OFF;
            drv_nxt = 1'b0;
          end
        endcase
      end
    end

    // Channel registers; reset holds the drive low
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        st_r[i]   <= TPW_FORCED_OFF;
        drv_r[i]  <= 1'b0;                                // [R15]
        samp_r[i] <= '0;
        acc_r     <= '0;
      end
      else
      begin
        st_r[i]   <= st_nxt;
        drv_r[i]  <= drv_nxt;
        samp_r[i] <= samp_nxt;                            // [R10]
        acc_r     <= acc_nxt;
      end
    end

    // Checks per channel
    property p_fall_hold;
      @(posedge clk_in) disable iff (rst_in)
      $rose(drv_r[i]) |-> $past(ph[i]) >= QTR_C;
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("rise in off time"); // [R4] [R5]

    property p_cross;
      @(posedge clk_in) disable iff (rst_in)
      (en_s2_r && st_r[i] == TPW_ARMED && cmp[i] && ph[i] != LAST)
        |=> drv_r[i];
    endproperty
    a_cross: assert property (p_cross) else $error("no rise on crossing"); // [R7]

    property p_stay;
      @(posedge clk_in) disable iff (rst_in)
      (drv_r[i] && en_s2_r && ph[i] != LAST) |=> drv_r[i];
    endproperty
    a_stay: assert property (p_stay) else $error("early fall"); // [R8]

    property p_sample;
      @(posedge clk_in) disable iff (rst_in)
      (samp_r[i] != $past(samp_r[i])) |->
        $past(st_r[i]) == TPW_FORCED_OFF && $past(ph[i]) == SET_C;
    endproperty
    a_sample: assert property (p_sample) else $error("stray sample"); // [R9]
  end

  // Outputs taken straight from the registers
  always_comb
  begin
    phase_one_drive_out    = drv_r[0];
    phase_two_drive_out    = drv_r[1];
    mean_phase_current_out = mean_r;                      // [R10]
    switching_active_out   = act_r;
  end

  // Named steps of a cycle end
  sequence s_tick1;
    en_s2_r && cnt_r == LAST;
  endsequence
  sequence s_tick2;
    en_s2_r && cnt_r == HALF_C - 1'b1;
  endsequence

  property p_term1;
    @(posedge clk_in) disable iff (rst_in)
    s_tick1 |=> !phase_one_drive_out ##1 !phase_one_drive_out;
  endproperty
  a_term1: assert property (p_term1) else $error("phase one not ended"); // [R1] [R2]

  property p_term2;
    @(posedge clk_in) disable iff (rst_in)
    s_tick2 |=> !phase_two_drive_out ##1 !phase_two_drive_out;
  endproperty
  a_term2: assert property (p_term2) else $error("phase two not ended"); // [R3]

  property p_mean;
    @(posedge clk_in) disable iff (rst_in)
    ##1 mean_phase_current_out ==
      DW'(({1'b0, $past(samp_r[0])} + {1'b0, $past(samp_r[1])}) >> 1);
  endproperty
  a_mean: assert property (p_mean) else $error("bad mean"); // [R11]

  property p_dis;
    @(posedge clk_in) disable iff (rst_in)
    !en_s2_r |=> !phase_one_drive_out && !phase_two_drive_out && cnt_r == '0;
  endproperty
  a_dis: assert property (p_dis) else $error("switching while off"); // [R14]

  property p_rst;
    @(posedge clk_in)
    rst_in |=> !phase_one_drive_out && !phase_two_drive_out;
  endproperty
  a_rst: assert property (p_rst) else $error("drive high after reset"); // [R15]
endmodule : tpw_timing
`default_nettype wire

// >>> sim/tpw_driver_model.sv
// Behavioural half-bridge driver for one phase of the timing core.
// Assumes one drive level in and one sense word level from the bench.
`timescale 1ns/1ps
`default_nettype none
module tpw_driver_model #(
  parameter int DW = 8
)(
  input  wire logic          drive_in,     // Drive from the core
  input  wire logic [DW-1:0] level_in,     // Lower switch current
  output var  logic          upper_on_out, // Upper switch on
  output var  logic          lower_on_out, // Synchronous switch on
  output var  logic [DW-1:0] sense_out     // Sense word to the core
);
  // Falling drive swaps to the lower switch, rising swaps back
  always_comb
  begin
    upper_on_out = drive_in;
    lower_on_out = !drive_in;
    // Sense only valid while the lower switch conducts; junk otherwise
    sense_out    = lower_on_out ? level_in : ~level_in;
  end
endmodule : tpw_driver_model
`default_nettype wire

// >>> sim/two_phase_interleaved_pwm_timing_tb.sv
// Self-checking bench for the interleaved drive timing core.
// Assumes a short period parameter so each run stays brief.
`timescale 1ns/1ps
`default_nettype none
module two_phase_interleaved_pwm_timing_tb;
  localparam int P = 24;             // Short switching period
  logic       clk_in, rst_in, en;    // Clock, reset, frequency pin level
  logic [7:0] amp, lv1, lv2, s1, s2; // Amp level, currents, sense words
  logic       d1, d2, act, u1, l1, u2, l2; // Drives, active, switches
  logic [7:0] mean;                  // Mean current output
  int         n_errors, tests_run, cyc, t0, t1, t2, k, lo;
  logic [31:0] exp_q[$], got_q[$];   // Expected and seen values
  string      nm_q[$];               // Names of checked values
  tpw_timing #(.PERIOD_CYC(P), .DW(8)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .freq_set_disable_in(en), .error_amp_output_in(amp), .phase_one_current_in(s1),
    .phase_two_current_in(s2), .phase_one_drive_out(d1), .phase_two_drive_out(d2),
    .mean_phase_current_out(mean), .switching_active_out(act));
  tpw_driver_model i_drv1 (.drive_in(d1), .level_in(lv1), .upper_on_out(u1),
    .lower_on_out(l1), .sense_out(s1));
  tpw_driver_model i_drv2 (.drive_in(d2), .level_in(lv2), .upper_on_out(u2),
    .lower_on_out(l2), .sense_out(s2));
  // Clock of 100 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Cycle count and hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end
  // Monitor drains every queued note, oldest first, at each falling clock edge
  always @(negedge clk_in)
    while (got_q.size() > 0)
    begin
      tests_run++;
      if (got_q[0] !== exp_q[0])
      begin
        $display("[ERR] %s expected %0d seen %0d", nm_q[0], exp_q[0], got_q[0]);
        n_errors++;
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
      void'(nm_q.pop_front());
    end
  // Note an expectation and the value seen
  task note(input string n, input logic [31:0] e, input logic [31:0] g);
    nm_q.push_back(n);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : note
  // Wait for a falling drive on one channel, bounded
  task wait_fall(input int ch, output int t);
    logic p;
    p = (ch == 1) ? d1 : d2;
    for (int i = 0; i < 4 * P; i++)
    begin
      @(negedge clk_in);
      if (p === 1'b1 && ((ch == 1) ? d1 : d2) === 1'b0)
        break;
      p = (ch == 1) ? d1 : d2;
    end
    t = cyc;
  endtask : wait_fall
  // Count cycles of high drive over one period
  task count_high(input int ch, output int h);
    h = 0;
    repeat (P)
    begin
      @(negedge clk_in);
      if (((ch == 1) ? d1 : d2) === 1'b1)
        h++;
    end
  endtask : count_high
  // Print counts and verdict, then stop
  task results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // Main sequence
  initial
  begin
    n_errors = 0; tests_run = 0; cyc = 0;
    rst_in = 1'b1; en = 1'b1; amp = 8'h00; lv1 = 8'h10; lv2 = 8'h10;
    k = $urandom(19335);
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    amp = 8'($urandom_range(18, 23));
    repeat (3 * P) @(negedge clk_in);
    wait_fall(1, t0);
    wait_fall(1, t1);
    wait_fall(2, t2);
    note("period", P, t1 - t0);
    note("phase offset", P / 2, t2 - t1);
    // Channel one is high again by now; count from its next fall
    wait_fall(1, t0);
    lo = 0;
    while (d1 === 1'b0 && lo < P)
    begin
      @(negedge clk_in);
      lo++;
    end
    note("forced off held", 1, lo >= P / 4);
    note("rise after crossing", 1, lo < P);
    note("upper follows drive", d1, u1);
    $display("test timing done");
    amp = 8'h00;
    repeat (P) @(negedge clk_in);
    count_high(1, k);
    note("no rise below ramp", 0, k);
    $display("test compare done");
    for (int i = 0; i < 3; i++)
    begin
      lv1 = 8'($urandom);
      lv2 = 8'($urandom);
      repeat (3 * P) @(negedge clk_in);
      note("mean current", (9'(lv1) + 9'(lv2)) >> 1, mean);
    end
    // Even currents again; let the balance filter settle before the drives must rise
    lv1 = 8'h10;
    lv2 = 8'h10;
    repeat (24 * P) @(negedge clk_in);
    $display("test mean done");
    amp = 8'h14;
    en = 1'b0;
    repeat (4) @(negedge clk_in);
    count_high(1, k);
    count_high(2, t0);
    note("drives when disabled", 0, k + t0);
    note("active when disabled", 0, act);
    en = 1'b1;
    repeat (2 * P) @(negedge clk_in);
    wait_fall(1, t0);
    wait_fall(1, t1);
    note("period after enable", P, t1 - t0);
    $display("test disable done");
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    note("drives in reset", 0, d1 + d2);
    repeat (2) @(negedge clk_in);
    results();
  end
endmodule : two_phase_interleaved_pwm_timing_tb
`default_nettype wire
